// file: rtl/wdi_int_logic.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "wdi_cfg.svh"

// Overview of operation
// - Global enable set: interrupt output follows the pending flag.
// - Global enable clear: interrupt output stays low always.
// - Hardware reset and software reset clear every enable bit.
// - Cursor enable: after last break, window change sets cursor and pending flags.
// - Y break enable: tagged Y break sets pending, both fields alike.
// - Y break flag sets in retrace before a tagged window.
// - Terminator Y then terminator X break sets last-break flag and pending.
// - After last break no memory access until start delay expires.
// - Vertical retrace enable: blanking start sets retrace flag and pending.
// - Status read or resets clear flags 5..2; odd/even only by hardware reset.
// - A condition flag sets only when its enable bit is set.
// - Odd/even bit shows next field parity, valid through vertical period.
// - Pending sets on any enabled condition, clears on status read or reset.
// - Second status low bits report cursor window number, top priority.
// - Cursor window number valid from last break until delay expires.
// - Start delay is six bits of scan lines before list access.
module wdi_int_logic (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [5:0] i_start_delay,
    input wire logic i_line_tick,
    input wire logic i_ybrk_tagged,
    input wire logic i_ybrk_term,
    input wire logic i_xbrk_term,
    input wire logic i_xbrk_fetch,
    input wire logic i_vblank_start,
    input wire logic i_next_odd,
    input wire logic [6:0] i_cursor_win,
    output logic [7:0] o_rdata,
    output logic o_int,
    output logic o_mem_hold,
    output logic o_sw_reset
);

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------
    logic wr_enable;
    logic wr_ctrl;
    logic rd_flags;
    logic sw_rst;

    assign wr_enable = i_wr && (i_addr == `WDI_ADDR_ENABLE);
    assign wr_ctrl = i_wr && (i_addr == `WDI_ADDR_CTRL);
    assign rd_flags = i_rd && (i_addr == `WDI_ADDR_FLAGS);
    assign sw_rst = wr_ctrl && i_wdata[`WDI_CTRL_SWRST];

    // ----------------------------------------------------------------
    // Interrupt enable register
    // ----------------------------------------------------------------
    logic [7:0] enable_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enable_reg <= `WDI_ENABLE_RST;
        end else if (sw_rst) begin
            enable_reg <= `WDI_ENABLE_RST;
        end else if (wr_enable) begin
            enable_reg <= i_wdata;
        end
    end

    logic en_global;
    logic en_cursor;
    logic en_ybrk;
    logic en_last;
    logic en_vrt;

    assign en_global = enable_reg[`WDI_EN_GLOBAL];
    assign en_cursor = enable_reg[`WDI_EN_CURSOR];
    assign en_ybrk = enable_reg[`WDI_EN_YBRK];
    assign en_last = enable_reg[`WDI_EN_LAST];
    assign en_vrt = enable_reg[`WDI_EN_VRT];

    // ----------------------------------------------------------------
    // Break sequence tracking
    // ----------------------------------------------------------------
    // A terminator Y break arms; the next X break fetch decides.
    logic yterm_seen_reg;
    logic last_break;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            yterm_seen_reg <= 1'b0;
        end else if (i_ybrk_term) begin
            yterm_seen_reg <= 1'b1;
        end else if (i_xbrk_fetch) begin
            yterm_seen_reg <= 1'b0;
        end
    end

    assign last_break = yterm_seen_reg && i_xbrk_fetch && i_xbrk_term;

    // ----------------------------------------------------------------
    // Start delay and cursor window capture
    // ----------------------------------------------------------------
    wdi_pkg::wdi_delay_state_t dstate_reg;
    logic [5:0] delay_cnt_reg;
    logic [6:0] win_reg;
    logic win_changed;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dstate_reg <= wdi_pkg::WDI_DS_ACTIVE;
            delay_cnt_reg <= `WDI_DELAY_RST;
        end else begin
            unique case (dstate_reg)
                wdi_pkg::WDI_DS_ACTIVE: begin
                    if (last_break) begin
                        dstate_reg <= wdi_pkg::WDI_DS_WAIT;
                        delay_cnt_reg <= i_start_delay;
                    end
                end
                wdi_pkg::WDI_DS_WAIT: begin
                    if (i_line_tick) begin
                        if (delay_cnt_reg == `WDI_DELAY_RST) begin
                            dstate_reg <= wdi_pkg::WDI_DS_ACTIVE;
                        end else begin
                            delay_cnt_reg <= delay_cnt_reg - 6'h01;
                        end
                    end
                end
                default: begin
                    dstate_reg <= wdi_pkg::WDI_DS_ACTIVE;
                end
            endcase
        end
    end

    // Memory accesses are held off for the whole delay span
    assign o_mem_hold = (dstate_reg == wdi_pkg::WDI_DS_WAIT);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            win_reg <= `WDI_WIN_RST;
        end else if (last_break) begin
            // Held between captures so software can read it through the delay span
            win_reg <= i_cursor_win;
        end
    end

    // Compares the new window against the one reported last frame
    assign win_changed = last_break && (i_cursor_win != win_reg);

    // ----------------------------------------------------------------
    // Condition flags and pending
    // ----------------------------------------------------------------
    logic [3:0] set_vec;
    logic [3:0] flag_vec;
    logic any_set;
    logic pending;

    // Each flag is gated by its own enable bit
    assign set_vec[3] = en_cursor && win_changed;
    assign set_vec[2] = en_ybrk && i_ybrk_tagged;
    assign set_vec[1] = en_last && last_break;
    assign set_vec[0] = en_vrt && i_vblank_start;
    assign any_set = |set_vec;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            wdi_sticky_flag u_flag (
                .i_clk(i_clk),
                .i_nrst(i_nrst),
                .i_set(set_vec[gi]),
                .i_clr(rd_flags || sw_rst),
                .o_flag(flag_vec[gi])
            );
        end
    endgenerate

    wdi_sticky_flag u_pending (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_set(any_set),
        .i_clr(rd_flags || sw_rst),
        .o_flag(pending)
    );

    // ----------------------------------------------------------------
    // Odd/even field flag (not cleared by reads)
    // ----------------------------------------------------------------
    logic odd_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            odd_reg <= 1'b0;
        end else begin
            odd_reg <= i_next_odd;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_int <= 1'b0;
        end else begin
            o_int <= en_global && (pending || any_set);
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        unique case (i_addr)
            `WDI_ADDR_FLAGS: begin
                rdata_next[`WDI_FL_ODD] = odd_reg;
                rdata_next[`WDI_FL_CURSOR] = flag_vec[3];
                rdata_next[`WDI_FL_YBRK] = flag_vec[2];
                rdata_next[`WDI_FL_LAST] = flag_vec[1];
                rdata_next[`WDI_FL_VRT] = flag_vec[0];
            end
            `WDI_ADDR_PEND: begin
                rdata_next[`WDI_PEND_BIT] = pending;
                rdata_next[6:0] = win_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sw_reset <= 1'b0;
        end else begin
            o_sw_reset <= sw_rst;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // A set in the same cycle as a clear wins, so clear checks exclude it
    chk_int_global_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !en_global |=> !o_int)
        else $error("interrupt high with global enable clear");

    chk_int_follows_pend: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (en_global && pending) |=> o_int)
        else $error("interrupt low while pending and enabled");

    chk_int_needs_pend: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!pending && !any_set) |=> !o_int)
        else $error("interrupt high with nothing pending");

    chk_enable_swreset: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sw_rst |=> (enable_reg == 8'h00))
        else $error("enables not cleared by software reset");

    chk_flags_read_clr: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (rd_flags && !any_set) |=> (flag_vec == 4'h0) && !pending)
        else $error("flags not cleared by status read");

    chk_swrst_clr: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (sw_rst && !any_set) |=> (flag_vec == 4'h0) && !pending)
        else $error("flags not cleared by software reset");

    chk_odd_kept_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (rd_flags && i_next_odd == odd_reg) |=> $stable(odd_reg))
        else $error("odd flag disturbed by status read");

    chk_odd_follows_in: assert property (@(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> (odd_reg == $past(i_next_odd)))
        else $error("odd flag does not track next field");

    chk_flag_needs_en: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!en_vrt && !set_vec[0] && (flag_vec[0] == 1'b0)) |=> !flag_vec[0])
        else $error("retrace flag set while disabled");

    chk_vrt_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (en_vrt && i_vblank_start) |=> flag_vec[0] && pending)
        else $error("retrace flag not raised");

    chk_ybrk_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (en_ybrk && i_ybrk_tagged) |=> flag_vec[2] && pending)
        else $error("y break flag not raised");

    chk_cursor_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (en_cursor && win_changed) |=> flag_vec[3] && pending)
        else $error("cursor window flag not raised");

    chk_pend_any_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        any_set |=> pending)
        else $error("pending not set by enabled condition");

    chk_pend_rdata: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == `WDI_ADDR_PEND) |=> (o_rdata == {$past(pending), $past(win_reg)}))
        else $error("pending register read data wrong");

    chk_hold_after_last: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (last_break && dstate_reg == wdi_pkg::WDI_DS_ACTIVE) |=> o_mem_hold)
        else $error("memory hold missing after last break");

    chk_delay_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (last_break && !o_mem_hold) |=> (delay_cnt_reg == $past(i_start_delay)))
        else $error("start delay not loaded");

    chk_delay_count_down: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (o_mem_hold && i_line_tick && delay_cnt_reg != `WDI_DELAY_RST)
        |=> o_mem_hold && (delay_cnt_reg == $past(delay_cnt_reg) - 6'h01))
        else $error("start delay not counting down");

    chk_delay_exit: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (o_mem_hold && i_line_tick && delay_cnt_reg == `WDI_DELAY_RST) |=> !o_mem_hold)
        else $error("memory hold not released at delay end");

    chk_last_flag_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (en_last && last_break) |=> flag_vec[1] ##0 pending)
        else $error("last break flag not raised");

    chk_win_capture: assert property (@(posedge i_clk) disable iff (!i_nrst)
        last_break |=> (win_reg == $past(i_cursor_win)))
        else $error("cursor window not captured");

    chk_win_report_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !last_break |=> $stable(win_reg))
        else $error("cursor window changed between captures");

endmodule : wdi_int_logic

// file: rtl/wdi_cfg.svh
`ifndef WDI_CFG_SVH
`define WDI_CFG_SVH

// Register addresses on the plain port
`define WDI_ADDR_ENABLE 2'h0
`define WDI_ADDR_FLAGS 2'h1
`define WDI_ADDR_PEND 2'h2
`define WDI_ADDR_CTRL 2'h3

// Enable register bit positions
`define WDI_EN_GLOBAL 7
`define WDI_EN_CURSOR 5
`define WDI_EN_YBRK 4
`define WDI_EN_LAST 3
`define WDI_EN_VRT 2

// Condition flag bit positions
`define WDI_FL_ODD 6
`define WDI_FL_CURSOR 5
`define WDI_FL_YBRK 4
`define WDI_FL_LAST 3
`define WDI_FL_VRT 2

// Pending bit of the second status register
`define WDI_PEND_BIT 7

// Control register: bit 0 is the software reset command
`define WDI_CTRL_SWRST 0

// Reset values
`define WDI_ENABLE_RST 8'h00
`define WDI_FLAGS_RST 4'h0
`define WDI_WIN_RST 7'h00
`define WDI_DELAY_RST 6'h00

`endif

// file: rtl/wdi_pkg.sv
package wdi_pkg;

    typedef enum logic [1:0] {
        WDI_DS_ACTIVE,
        WDI_DS_WAIT
    } wdi_delay_state_t;

endpackage : wdi_pkg

// file: rtl/wdi_sticky_flag.sv
`timescale 1ns/100ps

// Sticky event flag: set wins over clear in the same cycle.
module wdi_sticky_flag (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_flag
);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end

endmodule : wdi_sticky_flag

// file: sim/wdi_host_model.sv
`timescale 1ns/100ps
`include "wdi_cfg.svh"
// ----
// Host side of the register port
// ----
module wdi_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_int,
    output logic [1:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 2'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : rd
    // Flags clear on read, so a blind read would lose events
    task automatic service(output logic [7:0] pend, output logic [7:0] fl);
        rd(`WDI_ADDR_PEND, pend);
        fl = 8'h00;
        if (pend[`WDI_PEND_BIT] === 1'b1 || i_int === 1'b1) begin
            rd(`WDI_ADDR_FLAGS, fl);
        end
    endtask : service
endmodule : wdi_host_model

// file: sim/window_display_interrupt_logic_tb_top.sv
`timescale 1ns/100ps
`include "wdi_cfg.svh"
// ----
// Bench for the interrupt logic
// ----
module window_display_interrupt_logic_tb_top;
    logic clk;
    logic nrst;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [5:0] ev;
    logic odd;
    logic [6:0] win;
    logic [7:0] rdata;
    logic irq;
    logic hold;
    logic swr;
    logic [7:0] p;
    logic [7:0] f;
    int num_errors = 0;
    int checks_done = 0;
    // Short delay keeps the hold wait to a few line ticks
    localparam logic [5:0] DLY = 6'h03;
    // Second frame runs with zero delay: a single tick must end the hold
    logic [5:0] dly;
    wdi_int_logic u_wdi_int_logic (
        .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_start_delay(dly), .i_line_tick(ev[5]),
        .i_ybrk_tagged(ev[1]), .i_ybrk_term(ev[2]), .i_xbrk_term(ev[4]),
        .i_xbrk_fetch(ev[3]), .i_vblank_start(ev[0]), .i_next_odd(odd),
        .i_cursor_win(win), .o_rdata(rdata), .o_int(irq),
        .o_mem_hold(hold), .o_sw_reset(swr)
    );
    wdi_host_model u_host (
        .i_clk(clk), .i_rdata(rdata), .i_int(irq), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 6'h00;
        #1;
    endtask : pulse
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic t_idle;
        u_host.rd(`WDI_ADDR_PEND, p);
        chk(p, 8'h00);
        u_host.rd(`WDI_ADDR_CTRL, p);
        chk(p, 8'h00);
        chk({6'h00, hold, irq}, 8'h00);
        u_host.wr(`WDI_ADDR_ENABLE, 8'h80);
        for (int i = 0; i < 3; i++) begin
            pulse(6'h01 << i);
        end
        pulse(6'h18);
        chk({7'h00, irq}, 8'h00);
        u_host.service(p, f);
        chk(p, 8'h00);
        repeat (4) pulse(6'h20);
    endtask : t_idle
    task automatic t_no_global;
        u_host.wr(`WDI_ADDR_ENABLE, 8'h3C);
        odd <= 1'b1;
        pulse(6'h01);
        chk({7'h00, irq}, 8'h00);
        u_host.service(p, f);
        chk(p, 8'h80);
        chk(f, 8'h44);
        u_host.rd(`WDI_ADDR_PEND, p);
        chk(p, 8'h00);
    endtask : t_no_global
    task automatic t_global;
        u_host.wr(`WDI_ADDR_ENABLE, 8'hBC);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            odd <= i[1];
            pulse(i[0] ? 6'h02 : 6'h01);
            chk({7'h00, irq}, 8'h01);
            repeat (3) @(posedge clk);
            #1 chk({7'h00, irq}, 8'h01);
            u_host.service(p, f);
            chk(f, {1'b0, i[1], 6'h00} | (i[0] ? 8'h10 : 8'h04));
            @(posedge clk);
            #1 chk({7'h00, irq}, 8'h00);
        end
    endtask : t_global
    task automatic t_last;
        @(posedge clk);
        odd <= 1'b0;
        win <= 7'h15;
        for (int i = 0; i < 2; i++) begin
            dly <= (i == 0) ? DLY : 6'h00;
            pulse(6'h04);
            pulse(6'h18);
            chk({6'h00, hold, irq}, 8'h03);
            @(posedge clk);
            win <= 7'h2A;
            u_host.service(p, f);
            chk(p, 8'h95);
            chk(f, (i == 0) ? 8'h28 : 8'h08);
            repeat (dly) pulse(6'h20);
            chk({7'h00, hold}, 8'h01);
            pulse(6'h20);
            chk({7'h00, hold}, 8'h00);
            @(posedge clk);
            win <= 7'h15;
        end
    endtask : t_last
    task automatic t_resets;
        for (int k = 0; k < 2; k++) begin
            u_host.wr(`WDI_ADDR_ENABLE, 8'hBC);
            pulse(6'h01);
            if (k == 0) begin
                u_host.wr(`WDI_ADDR_CTRL, 8'h01);
                #1 chk({7'h00, swr}, 8'h01);
            end else begin
                @(posedge clk);
                nrst <= 1'b0;
                @(posedge clk);
                nrst <= 1'b1;
            end
            @(posedge clk);
            #1 chk({7'h00, irq}, 8'h00);
            pulse(6'h01);
            chk({7'h00, irq}, 8'h00);
            u_host.rd(`WDI_ADDR_PEND, p);
            chk({p[7], 7'h00}, 8'h00);
        end
    endtask : t_resets
    initial begin
        nrst = 1'b0;
        ev = 6'h00;
        odd = 1'b0;
        win = 7'h00;
        dly = DLY;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_idle();
        t_no_global();
        t_global();
        t_last();
        t_resets();
        finish_test();
    end
    // Whole run is under two hundred cycles; this only cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule : window_display_interrupt_logic_tb_top
